// ===== core/dserc_pkg.sv
`default_nettype none
package dserc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_POL_FAULT_ADDR = 8'h08;
  localparam logic [7:0] XLAT_SRC1_ADDR     = 8'h09;
  localparam logic [7:0] XLAT_DST1_ADDR     = 8'h0A;
  localparam logic [7:0] XLAT_SRC2_ADDR     = 8'h0B;
  localparam logic [7:0] XLAT_DST2_ADDR     = 8'h0C;
  localparam logic [7:0] BRIDGE_TIMING_ADDR = 8'h0D;
  localparam logic [7:0] DET_LIMIT_ADDR     = 8'h0F;
  localparam logic [7:0] DET_COUNT_ADDR     = 8'h10;
  localparam logic [7:0] CORR_LIMIT_ADDR    = 8'h11;
  localparam logic [7:0] CORR_COUNT_ADDR    = 8'h12;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int VS_INV_BIT    = 7;
  localparam int HS_INV_BIT    = 6;
  localparam int MATCH_DBL_BIT = 4;
  localparam int STAGGER_BIT   = 3;
  localparam int AUTO_CLR_BIT  = 2;
  localparam int LOC_ACK_BIT   = 7;
  localparam int SEL_LSB       = 0;
  localparam int SEL_W         = 2;
  localparam int SETUP_LSB     = 5;
  localparam int SETUP_W       = 2;
  localparam int RATE_LSB      = 2;
  localparam int RATE_W        = 3;
  localparam int TIMEOUT_LSB   = 0;
  localparam int TIMEOUT_W     = 2;
  localparam int ADDR_LSB      = 1;
  localparam int ADDR_W        = 7;
  localparam logic [7:0] OUT_POL_RESET  = 8'h00;
  localparam logic [7:0] OUT_POL_WMASK  = 8'hDF;
  localparam logic [7:0] XLAT_WMASK     = 8'hFE;
  localparam logic [7:0] XLAT_RESET     = 8'h00;
  localparam logic [7:0] LIMIT_RESET    = 8'h00;
  localparam logic [1:0] SETUP_RESET    = 2'h1;
  localparam logic [2:0] RATE_RESET     = 3'h5;
  localparam logic [1:0] TIMEOUT_RESET  = 2'h2;

  // Error flag source codes
  localparam logic [1:0] SRC_DET  = 2'h0;
  localparam logic [1:0] SRC_CORR = 2'h1;
  // Timeout code that disables the remote timeout
  localparam logic [1:0] TIMEOUT_OFF = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int AUTO_CLR_NS    = 1000;
  localparam int AUTO_CLR_CYC   = (AUTO_CLR_NS * CLK_MHZ + 999) / 1000;
  localparam int TO0_US = 64;
  localparam int TO1_US = 256;
  localparam int TO2_US = 1024;
  localparam int TO_WIDTH = 16;
  localparam logic [TO_WIDTH-1:0] TO0_CYC = TO_WIDTH'(TO0_US * CLK_MHZ);
  localparam logic [TO_WIDTH-1:0] TO1_CYC = TO_WIDTH'(TO1_US * CLK_MHZ);
  localparam logic [TO_WIDTH-1:0] TO2_CYC = TO_WIDTH'(TO2_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dserc_reg_req_t;

  typedef struct packed {
    logic       verticalSync;
    logic       horizontalSync;
    logic       pixelOutBit0;
    logic       pixelOutBit1;
  } dserc_video_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } dserc_i2c_addr_t;
endpackage
`default_nettype wire

// ===== core/dserc_timeout.sv
`default_nettype none
module dserc_timeout
  import dserc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] slaveRemoteTimeoutSel,
  input  wire logic       waitActive,
  output var  logic       timeoutPulse
);
  typedef struct packed {
    logic [TO_WIDTH-1:0] cnt;
    logic                pulse;
  } dserc_to_state_t;

  dserc_to_state_t st_q;
  dserc_to_state_t st_d;
  logic [TO_WIDTH-1:0] limit;

  always_comb begin
    case (slaveRemoteTimeoutSel)
      2'h0:    limit = TO0_CYC;
      2'h1:    limit = TO1_CYC;
      default: limit = TO2_CYC;
    endcase
    st_d = st_q;
    st_d.pulse = 1'b0;
    // Code 11 never fires; counter still held at zero
    if (!waitActive || slaveRemoteTimeoutSel == TIMEOUT_OFF) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == limit - 1'b1) begin
      st_d.pulse = 1'b1;
      st_d.cnt   = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign timeoutPulse = st_q.pulse;
endmodule // dserc_timeout
`default_nettype wire

// ===== core/dserc_cfg.sv
`default_nettype none
module dserc_cfg
  import dserc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire dserc_reg_req_t  regReq,
  output var  logic [7:0]      regRdata,
  input  wire logic            syncEncodeEn,
  input  wire logic            syncTrackingEn,
  input  wire dserc_video_t    videoIn,
  output var  dserc_video_t    videoOut,
  input  wire logic            detectedFaultEvent,
  input  wire logic            correctedFaultEvent,
  output var  logic            faultFlag,
  output var  logic [7:0]      detectedFaultCount,
  output var  logic [7:0]      correctedFaultCount,
  input  wire dserc_i2c_addr_t i2cAddrIn,
  output var  dserc_i2c_addr_t i2cAddrOut,
  input  wire logic            slaveAddrPhase,
  input  wire logic            forwardChanUp,
  input  wire logic            remoteWait,
  output var  logic            localAck,
  output var  logic            remoteTimeout,
  output var  logic [1:0]      slaveSetupHoldSel,
  output var  logic [2:0]      masterRateSel,
  output var  logic            outputStaggerOff,
  output var  logic            matchedDoubleFlag
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      outPol;
    logic [7:0]      src1;
    logic [7:0]      dst1;
    logic [7:0]      src2;
    logic [7:0]      dst2;
    logic            locAck;
    logic [1:0]      setupHold;
    logic [2:0]      rate;
    logic [1:0]      timeoutSel;
    logic [7:0]      detLimit;
    logic [7:0]      corrLimit;
    logic [7:0]      detCnt;
    logic [7:0]      corrCnt;
    logic            flag;
    logic            clrArmed;
    logic [7:0]      clrCnt;
    logic [7:0]      rdata;
    dserc_video_t    video;
    dserc_i2c_addr_t xlat;
    logic            ack;
    logic            toPulse;
  } dserc_cfg_state_t;

  dserc_cfg_state_t st_q;
  dserc_cfg_state_t st_d;
  logic             toPulse;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Counters stick at full scale so a burst cannot wrap below the limit
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  function automatic logic addr_hit(input logic [7:0] regv, input logic [6:0] a);
    return regv[ADDR_LSB +: ADDR_W] == a;
  endfunction

  // ----------------------------------------------------------------
  // Remote timeout
  // ----------------------------------------------------------------
  // Pulse is registered again below so the port leaves a flop here too
  dserc_timeout u_timeout (
    .clk                   (clk),
    .rst                   (rst),
    .slaveRemoteTimeoutSel (st_q.timeoutSel),
    .waitActive            (remoteWait),
    .timeoutPulse          (toPulse)
  );

  always_comb begin
    logic detOver;
    logic corrOver;
    logic vsInv;
    logic hsInv;
    detOver  = 1'b0;
    corrOver = 1'b0;
    vsInv    = 1'b0;
    hsInv    = 1'b0;
    st_d = st_q;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (regReq.wrEn) begin
      case (regReq.addr)
        OUT_POL_FAULT_ADDR: begin
          st_d.outPol = regReq.wdata & OUT_POL_WMASK;
          // Matched flag only takes when encoding off and tracking on
          if (syncEncodeEn || !syncTrackingEn) begin
            st_d.outPol[MATCH_DBL_BIT] = st_q.outPol[MATCH_DBL_BIT];
          end
        end
        // Reserved bit 0 is dropped on the way in, so it always reads 0
        XLAT_SRC1_ADDR: begin
          st_d.src1 = regReq.wdata & XLAT_WMASK;
        end
        XLAT_DST1_ADDR: begin
          st_d.dst1 = regReq.wdata & XLAT_WMASK;
        end
        XLAT_SRC2_ADDR: begin
          st_d.src2 = regReq.wdata & XLAT_WMASK;
        end
        XLAT_DST2_ADDR: begin
          st_d.dst2 = regReq.wdata & XLAT_WMASK;
        end
        BRIDGE_TIMING_ADDR: begin
          st_d.locAck     = regReq.wdata[LOC_ACK_BIT];
          st_d.setupHold  = regReq.wdata[SETUP_LSB +: SETUP_W];
          st_d.rate       = regReq.wdata[RATE_LSB +: RATE_W];
          st_d.timeoutSel = regReq.wdata[TIMEOUT_LSB +: TIMEOUT_W];
        end
        // Limits take any value; a limit of 0xFF can never be exceeded
        DET_LIMIT_ADDR: begin
          st_d.detLimit = regReq.wdata;
        end
        CORR_LIMIT_ADDR: begin
          st_d.corrLimit = regReq.wdata;
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads, unmapped reads as zero
    // ----------------------------------------------------------------
    // Read data holds until the next read strobe
    if (regReq.rdEn) begin
      case (regReq.addr)
        OUT_POL_FAULT_ADDR: begin
          st_d.rdata = st_q.outPol;
        end
        XLAT_SRC1_ADDR: begin
          st_d.rdata = st_q.src1;
        end
        XLAT_DST1_ADDR: begin
          st_d.rdata = st_q.dst1;
        end
        XLAT_SRC2_ADDR: begin
          st_d.rdata = st_q.src2;
        end
        XLAT_DST2_ADDR: begin
          st_d.rdata = st_q.dst2;
        end
        BRIDGE_TIMING_ADDR: begin
          st_d.rdata = {st_q.locAck, st_q.setupHold, st_q.rate,
                        st_q.timeoutSel};
        end
        DET_LIMIT_ADDR: begin
          st_d.rdata = st_q.detLimit;
        end
        DET_COUNT_ADDR: begin
          st_d.rdata = st_q.detCnt;
        end
        CORR_LIMIT_ADDR: begin
          st_d.rdata = st_q.corrLimit;
        end
        CORR_COUNT_ADDR: begin
          st_d.rdata = st_q.corrCnt;
        end
        default:            st_d.rdata = 8'h00;
      endcase
    end

    // ----------------------------------------------------------------
    // Error counters and flag
    // ----------------------------------------------------------------
    detOver  = st_q.detCnt > st_q.detLimit;
    corrOver = st_q.corrCnt > st_q.corrLimit;
    case (st_q.outPol[SEL_LSB +: SEL_W])
      SRC_DET: begin
        st_d.flag = detOver;
      end
      SRC_CORR: begin
        st_d.flag = corrOver;
      end
      // Both upper codes watch either counter
      default: begin
        st_d.flag = detOver || corrOver;
      end
    endcase

    // ----------------------------------------------------------------
    // Auto-clear
    // ----------------------------------------------------------------
    // Clear counter runs from the flag's rising edge
    if (st_q.clrArmed) begin
      st_d.clrCnt = st_q.clrCnt + 8'h01;
    end else if (st_q.outPol[AUTO_CLR_BIT] && st_d.flag && !st_q.flag) begin
      st_d.clrArmed = 1'b1;
      st_d.clrCnt   = 8'h01;
    end

    if (detectedFaultEvent) begin
      st_d.detCnt = sat_inc(st_q.detCnt);
    end
    if (correctedFaultEvent) begin
      st_d.corrCnt = sat_inc(st_q.corrCnt);
    end
    // Clear beats a same-cycle count; one lost event is accepted
    if (st_q.clrArmed && st_q.clrCnt == 8'(AUTO_CLR_CYC)) begin
      st_d.detCnt   = 8'h00;
      st_d.corrCnt  = 8'h00;
      st_d.clrArmed = 1'b0;
      st_d.clrCnt   = 8'h00;
    end
    if (!st_q.outPol[AUTO_CLR_BIT]) begin
      st_d.clrArmed = 1'b0;
      st_d.clrCnt   = 8'h00;
    end

    // ----------------------------------------------------------------
    // Output inversion
    // ----------------------------------------------------------------
    // Mismatched single/double mode makes inversion unsafe; software keeps off
    vsInv = st_q.outPol[VS_INV_BIT];
    hsInv = st_q.outPol[HS_INV_BIT];
    st_d.video = videoIn;
    if (syncEncodeEn) begin
      st_d.video.verticalSync   = videoIn.verticalSync ^ vsInv;
      st_d.video.horizontalSync = videoIn.horizontalSync ^ hsInv;
    end else begin
      st_d.video.pixelOutBit0 = videoIn.pixelOutBit0 ^ vsInv;
      st_d.video.pixelOutBit1 = videoIn.pixelOutBit1 ^ hsInv;
    end

    // ----------------------------------------------------------------
    // I2C bridge
    // ----------------------------------------------------------------
    // First pair wins when both sources hold the same address
    st_d.xlat = i2cAddrIn;
    if (i2cAddrIn.valid && addr_hit(st_q.src1, i2cAddrIn.addr)) begin
      st_d.xlat.addr = st_q.dst1[ADDR_LSB +: ADDR_W];
    end else if (i2cAddrIn.valid && addr_hit(st_q.src2, i2cAddrIn.addr)) begin
      st_d.xlat.addr = st_q.dst2[ADDR_LSB +: ADDR_W];
    end
    st_d.ack     = slaveAddrPhase && !forwardChanUp && st_q.locAck;
    st_d.toPulse = toPulse;
  end

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Blanket clear first, then the fields with named reset values
      st_q            <= '0;
      st_q.outPol     <= OUT_POL_RESET;
      st_q.src1       <= XLAT_RESET;
      st_q.dst1       <= XLAT_RESET;
      st_q.src2       <= XLAT_RESET;
      st_q.dst2       <= XLAT_RESET;
      st_q.setupHold  <= SETUP_RESET;
      st_q.rate       <= RATE_RESET;
      st_q.timeoutSel <= TIMEOUT_RESET;
      st_q.detLimit   <= LIMIT_RESET;
      st_q.corrLimit  <= LIMIT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata            = st_q.rdata;
  assign videoOut            = st_q.video;
  assign faultFlag           = st_q.flag;
  assign detectedFaultCount  = st_q.detCnt;
  assign correctedFaultCount = st_q.corrCnt;
  assign i2cAddrOut          = st_q.xlat;
  assign localAck            = st_q.ack;
  assign remoteTimeout       = st_q.toPulse;
  assign slaveSetupHoldSel   = st_q.setupHold;
  assign masterRateSel       = st_q.rate;
  assign outputStaggerOff    = st_q.outPol[STAGGER_BIT];
  assign matchedDoubleFlag   = st_q.outPol[MATCH_DBL_BIT];
endmodule // dserc_cfg
`default_nettype wire

// ===== dv/dserc_monitor.sv
`default_nettype none
module dserc_monitor
  import dserc_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst,
  input wire dserc_reg_req_t regReq,
  input wire logic [7:0]     regRdata,
  input wire logic           slaveAddrPhase,
  input wire logic           forwardChanUp,
  input wire logic           remoteWait,
  input wire logic           localAck,
  input wire logic           remoteTimeout,
  input wire logic           detectedFaultEvent,
  input wire logic [7:0]     detectedFaultCount,
  input wire logic [7:0]     correctedFaultCount,
  input wire logic [1:0]     slaveSetupHoldSel,
  input wire logic [2:0]     masterRateSel,
  input wire logic           faultFlag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] waitRun_q;
  // Length of the current wait, bounds the earliest legal timeout
  always_ff @(posedge clk or posedge rst)
    if (rst) waitRun_q <= 16'h0000;
    else waitRun_q <= remoteWait ? waitRun_q + 16'h0001 : 16'h0000;
  loc_ack_a: assert property (
    localAck |-> $past(slaveAddrPhase && !forwardChanUp))
    else $error("local ack without cause");
  to_pulse_a: assert property (
    remoteTimeout |=> !remoteTimeout) else $error("timeout pulse too long");
  to_min_a: assert property (
    remoteTimeout |-> waitRun_q >= 16'h0C80) else $error("timeout too early");
  det_evt_a: assert property (
    detectedFaultCount > $past(detectedFaultCount) |-> $past(detectedFaultEvent))
    else $error("count rose without event");
  corr_step_a: assert property (
    correctedFaultCount != $past(correctedFaultCount) |-> correctedFaultCount == 8'h00
      || correctedFaultCount == $past(correctedFaultCount) + 8'h01)
    else $error("count jumped");
  rst_val_a: assert property (
    $past(rst) |-> slaveSetupHoldSel == SETUP_RESET && masterRateSel == RATE_RESET)
    else $error("bad field reset");
  field_wr_a: assert property (
    regReq.wrEn && regReq.addr == BRIDGE_TIMING_ADDR |=> slaveSetupHoldSel ==
      $past(regReq.wdata[6:5]) && masterRateSel == $past(regReq.wdata[4:2]))
    else $error("field not updated");
  rsvd_bit_a: assert property (
    regReq.rdEn && regReq.addr inside {[XLAT_SRC1_ADDR:XLAT_DST2_ADDR]} |=> !regRdata[0])
    else $error("reserved bit set");
  cover property ($rose(faultFlag));
  cover property (remoteTimeout);
  cover property (localAck);
endmodule // dserc_monitor
bind dserc_cfg dserc_monitor u_mon (.clk(clk), .rst(rst), .regReq(regReq),
  .regRdata(regRdata), .slaveAddrPhase(slaveAddrPhase), .forwardChanUp(forwardChanUp),
  .remoteWait(remoteWait), .localAck(localAck), .remoteTimeout(remoteTimeout),
  .detectedFaultEvent(detectedFaultEvent), .detectedFaultCount(detectedFaultCount),
  .correctedFaultCount(correctedFaultCount), .slaveSetupHoldSel(slaveSetupHoldSel),
  .masterRateSel(masterRateSel), .faultFlag(faultFlag));
`default_nettype wire

// ===== dv/dserc_partner.sv
`default_nettype none
module dserc_partner (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic linkDown,
  input  wire logic slow,
  input  wire logic addrPhase,
  output wire logic forwardChanUp,
  output wire logic remoteWait
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] busy_q;
  // Prompt peripheral stretches briefly; slow one holds the wait
  always_ff @(posedge clk or posedge rst)
    if (rst) busy_q <= 3'h0;
    else if (addrPhase) busy_q <= 3'h4;
    else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
  assign forwardChanUp = !linkDown;
  assign remoteWait = slow || busy_q != 3'h0;
endmodule // dserc_partner
`default_nettype wire

// ===== dv/test_deser_output_error_i2c_cfg.sv
`default_nettype none
module test_deser_output_error_i2c_cfg
  import dserc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] RA [8] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F, 8'h0E};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h36, 8'h00, 8'h00};
  localparam logic [6:0] XI [3] = '{7'h50, 7'h33, 7'h12};
  localparam logic [6:0] XO [3] = '{7'h21, 7'h44, 7'h12};
  localparam int TO [4] = '{3200, 12800, 51200, 3200};
  logic clk, rst, encEn, trkEn, detEvt, corrEvt, addrPhase, linkDown, slow;
  logic fwdUp, rWait, localAck, remoteTimeout, faultFlag, stagOff, dblFlag;
  logic [7:0] regRdata, detCount, expQ [$];
  logic [2:0] chk, pend;
  logic [3:0] e;
  logic [31:0] rnd;
  int mismatches, n_tests, k;
  dserc_reg_req_t regReq;
  dserc_video_t vin, vout;
  dserc_i2c_addr_t ain, aout;
  dserc_cfg i_dut (.clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .syncEncodeEn(encEn), .syncTrackingEn(trkEn), .videoIn(vin), .videoOut(vout),
    .detectedFaultEvent(detEvt), .correctedFaultEvent(corrEvt), .faultFlag(faultFlag),
    .detectedFaultCount(detCount), .correctedFaultCount(), .i2cAddrIn(ain), .i2cAddrOut(aout),
    .slaveAddrPhase(addrPhase), .forwardChanUp(fwdUp), .remoteWait(rWait),
    .localAck(localAck), .remoteTimeout(remoteTimeout), .slaveSetupHoldSel(),
    .masterRateSel(), .outputStaggerOff(stagOff), .matchedDoubleFlag(dblFlag));
  dserc_partner i_far (.clk(clk), .rst(rst), .linkDown(linkDown), .slow(slow),
    .addrPhase(addrPhase), .forwardChanUp(fwdUp), .remoteWait(rWait));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: expected %0h got %0h", $time, x, g);
    end
  endtask
  // One checker per result kind; all share the counting in cmp8
  task automatic cmp_reg(input logic [7:0] x, input logic [7:0] g);
    cmp8(x, g);
  endtask
  task automatic cmp_video(input logic [7:0] x, input logic [7:0] g);
    cmp8(x, g);
  endtask
  task automatic cmp_bridge(input logic [7:0] x, input logic [7:0] g);
    cmp8(x, g);
  endtask
  task automatic cmp_fault(input logic [7:0] x, input logic [7:0] g);
    cmp8(x, g);
  endtask
  task automatic cmp_field(input logic [7:0] x, input logic [7:0] g);
    cmp8(x, g);
  endtask
  task automatic note(input logic [2:0] kd, input logic [7:0] x);
    chk <= kd;
    expQ.push_back(x);
  endtask
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    @(posedge clk);
    regReq <= '{w, r, a, d};
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, x);
    bus(1'b0, 1'b1, a, 8'h00);
    note(3'h1, x);
    bus(1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic evt(input logic d, c);
    @(posedge clk);
    {detEvt, corrEvt} <= {d, c};
    @(posedge clk);
    {detEvt, corrEvt} <= 2'h0;
  endtask
  // Results surface one cycle after the note, checked once settled
  always @(negedge clk) begin
    case (pend)
      3'h1: cmp_reg(expQ.pop_front(), regRdata);
      3'h2: cmp_video(expQ.pop_front(), {4'h0, vout});
      3'h3: cmp_bridge(expQ.pop_front(), {7'h00, localAck});
      3'h4: cmp_bridge(expQ.pop_front(), aout);
      3'h5: cmp_fault(expQ.pop_front(), {7'h00, faultFlag});
      3'h6: cmp_field(expQ.pop_front(), {6'h00, stagOff, dblFlag});
      3'h7: cmp_fault(expQ.pop_front(), detCount);
      default: ;
    endcase
    pend = chk;
    chk = 3'h0;
  end
  initial begin
    {rst, encEn, trkEn, detEvt, corrEvt, addrPhase, linkDown, slow} = 8'h80;
    {regReq, vin, ain, chk, pend} = '0;
    {mismatches, n_tests, k} = '0;
    rnd = 32'h0000CCB6;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (RA[i]) rd(RA[i], RV[i]);
    for (int i = 1; i < 7; i++) begin
      rnd = xs(rnd);
      wr(RA[i], rnd[7:0]);
      rd(RA[i], rnd[7:0] & (i < 5 ? XLAT_WMASK : 8'hFF));
    end
    @(posedge clk);
    {encEn, trkEn} <= 2'h3;
    wr(OUT_POL_FAULT_ADDR, 8'h10);
    rd(OUT_POL_FAULT_ADDR, 8'h00);
    note(3'h6, 8'h00);
    @(posedge clk);
    encEn <= 1'b0;
    wr(OUT_POL_FAULT_ADDR, 8'hFF);
    rd(OUT_POL_FAULT_ADDR, 8'hDF);
    note(3'h6, 8'h03);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      encEn <= s[0];
      wr(OUT_POL_FAULT_ADDR, {s[2:1], 6'h00});
      repeat (4) begin
        rnd = xs(rnd);
        e = rnd[3:0] ^ (s[0] ? {s[2:1], 2'h0} : {2'h0, s[2:1]});
        @(posedge clk);
        vin <= rnd[3:0];
        note(3'h2, {4'h0, e});
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(BRIDGE_TIMING_ADDR, {i[1], 7'h36});
      @(posedge clk);
      {linkDown, addrPhase} <= {i[0], 1'b1};
      note(3'h3, {7'h00, i[1] & i[0]});
      @(posedge clk);
      addrPhase <= 1'b0;
    end
    wr(XLAT_SRC1_ADDR, 8'hA0);
    wr(XLAT_DST1_ADDR, 8'h42);
    wr(XLAT_SRC2_ADDR, 8'h66);
    wr(XLAT_DST2_ADDR, 8'h88);
    foreach (XI[i]) begin
      @(posedge clk);
      ain <= '{1'b1, XI[i]};
      note(3'h4, {1'b1, XO[i]});
    end
    wr(DET_LIMIT_ADDR, 8'h02);
    wr(CORR_LIMIT_ADDR, 8'h01);
    repeat (3) evt(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(OUT_POL_FAULT_ADDR, 8'(i));
      repeat (3) @(posedge clk);
      note(3'h5, {7'h00, i != 1});
    end
    repeat (60) @(posedge clk);
    note(3'h7, 8'h03);
    rd(DET_COUNT_ADDR, 8'h03);
    wr(OUT_POL_FAULT_ADDR, 8'h05);
    repeat (2) evt(1'b0, 1'b1);
    repeat (10) @(posedge clk);
    rd(CORR_COUNT_ADDR, 8'h02);
    repeat (50) @(posedge clk);
    rd(DET_COUNT_ADDR, 8'h00);
    rd(CORR_COUNT_ADDR, 8'h00);
    foreach (TO[i]) begin
      wr(BRIDGE_TIMING_ADDR, {6'h0D, i[1:0]});
      @(posedge clk);
      slow <= 1'b1;
      k = 0;
      // Bounded wait; code 3 must run out the bound silently
      while (!remoteTimeout && k < TO[i] + 20) begin
        @(negedge clk);
        k++;
      end
      cmp_bridge({7'h00, i != 3}, {7'h00, k >= TO[i] && k < TO[i] + 20});
      @(posedge clk);
      slow <= 1'b0;
    end
    repeat (3) @(posedge clk);
    cmp8(8'h00, 8'(expQ.size()));
    finish_test();
  end
endmodule // test_deser_output_error_i2c_cfg
`default_nettype wire
